// ### rtl/host_port_pkg.sv
// ============================================================
// Shared constants and types of the host serial port
package host_port_pkg;

    // Register bytes and state types
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        S_CMD = 2'b01, // Waiting for the command byte
        S_DATA = 2'b10 // Streaming data bytes
    } spi_phase_t;
    typedef enum logic [5:0] {
        I_IDLE = 6'b000001, // Bus free, after reset or STOP, or SPI selected
        I_DEV = 6'b000010, // Receiving slave address
        I_REG = 6'b000100, // Receiving register address
        I_WDATA = 6'b001000, // Receiving write data
        I_RDATA = 6'b010000, // Sending read data
        I_IGNORE = 6'b100000 // Not for us until next START
    } i2c_state_t;

    // ============================================================
    // Register map
    localparam byte_t FIFO_DATA_PORT = 8'h00; // Queue port, never increments
    localparam byte_t REG_COUNT = 8'h20; // Addresses below this are valid
    localparam byte_t ADDR_STEP = 8'h01; // Auto-increment step

    // ============================================================
    // Slave address straps
    localparam byte_t WR_ADDR_BASE = 8'hc0; // Base write address
    localparam byte_t WR_ADDR_ALT = 8'hd8; // Swapped slot value
    localparam logic [3:0] STRAP_IDX_ALT = 4'hc; // Slot that takes the base
    localparam logic [1:0] STRAP_GND = 2'h0; // Tied to ground
    localparam logic [1:0] STRAP_VL = 2'h1; // Tied to logic supply
    localparam logic [1:0] STRAP_SCL = 2'h2; // Tied to clock line
    localparam logic [1:0] STRAP_SDA = 2'h3; // Tied to data line

    // ============================================================
    // Bit counting and pin vector positions
    localparam logic [2:0] SPI_LAST_BIT = 3'h7; // Last bit of an SPI byte
    localparam logic [3:0] I2C_ACK_SLOT = 4'h8; // Bits before the ack slot
    localparam logic [2:0] MSB_IDX = 3'h7; // Top bit index of a byte
    localparam int PIN_SCL = 0; // Shared clock pin
    localparam int PIN_SDA = 1; // Data line
    localparam int PIN_CS = 2; // Select or strap 0
    localparam int PIN_MOSI = 3; // Serial in or strap 1
    localparam int PIN_MODE = 4; // Interface select strap
    localparam int NUM_PINS = 5; // Synchronised pins

endpackage

// ### rtl/host_serial_port.sv
// What this block does
// - Select pin chooses SPI or I2C
// - SPI single and burst, read and write
// - SPI address from command, increments unless zero
// - Burst write to zero feeds transmit queue
// - Burst read from zero drains receive queue
// - Select high ends burst; next starts command
// - Every SPI byte is eight clocks
// - I2C works up to 1 MHz
// - Two four-level straps give sixteen addresses
// - First byte: seven-bit address plus direction
// - Data edge while clock high is control
// - Idle bus: both lines released high
// - Ack address; ack register only if valid
// - Ack write data, increment unless zero
// - Read: set address, repeated START, send
// - Burst read increments unless address zero
// - Keep sending while host acknowledges
// - Ack holds data low through ninth clock
`timescale 1ns/10ps
`default_nettype none

module host_serial_port (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Interface select strap, high picks SPI
    input wire logic spi_select,
    // Host pins
    input wire logic sclk_scl,
    input wire logic select_or_strap0,
    input wire logic serial_in_or_strap1,
    output var logic serial_out,
    output var logic serial_out_oe,
    input wire logic sda_in,
    output var logic sda_out,
    output var logic sda_oe,
    // Register side
    output var host_port_pkg::byte_t reg_addr,
    output var host_port_pkg::byte_t reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd,
    input wire host_port_pkg::byte_t reg_rdata,
    // Status
    output var logic spi_active
);
    import host_port_pkg::*;

    // ============================================================
    // Pin synchronisers
    logic [NUM_PINS-1:0] pin_meta; // First stage, read by second only
    logic [NUM_PINS-1:0] pin_sync; // Second stage, safe to use
    logic scl_d; // Delayed clock for edges
    logic sda_d; // Delayed data for START/STOP
    logic [1:0] sync_fill; // Ones once both stages hold real pin levels

    // Two flops per pin; all pins settle in step
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
            scl_d <= 1'b0;
            sda_d <= 1'b1;
            sync_fill <= 2'b00;
        end else begin
            pin_meta <= {spi_select, serial_in_or_strap1, select_or_strap0,
                         sda_in, sclk_scl};
            pin_sync <= pin_meta;
            scl_d <= pin_sync[PIN_SCL];
            sda_d <= pin_sync[PIN_SDA];
            sync_fill <= {sync_fill[0], 1'b1};
        end
    end

    wire logic scl_s = pin_sync[PIN_SCL]; // Synced clock
    wire logic sda_s = pin_sync[PIN_SDA]; // Synced data line
    wire logic cs_s = pin_sync[PIN_CS]; // Synced select
    wire logic mosi_s = pin_sync[PIN_MOSI]; // Synced serial in
    wire logic mode_s = pin_sync[PIN_MODE]; // Synced interface select

    // Edge and condition detection; the three-clock lag bounds the link rate
    wire logic scl_rise = scl_s & ~scl_d;
    wire logic scl_fall = ~scl_s & scl_d; // Driving edge
    wire logic i2c_start = scl_s & scl_d & sda_d & ~sda_s;
    wire logic i2c_stop = scl_s & scl_d & ~sda_d & sda_s;

    // ============================================================
    // Slave address straps
    logic [1:0] seen_low; // Strap ever read low
    logic [1:0] seen_high; // Strap ever read high
    logic [1:0] diff_scl; // Strap ever differed from the clock

    // Learn each strap's tie; sticky, so a line strap settles at START
    // Waits for real pin levels: the reset zeros would make a supply tie read as a line tie
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_low <= 2'b00;
            seen_high <= 2'b00;
            diff_scl <= 2'b00;
        end else if (!mode_s && sync_fill[1]) begin
            seen_low <= seen_low | ~{mosi_s, cs_s};
            seen_high <= seen_high | {mosi_s, cs_s};
            diff_scl <= diff_scl | ({mosi_s, cs_s} ^ {2{scl_s}});
        end
    end

    // Four-level decode of one strap
    function automatic logic [1:0] strap_code(input logic lo, input logic hi,
                                              input logic dscl);
        return !hi ? STRAP_GND : !lo ? STRAP_VL : dscl ? STRAP_SDA : STRAP_SCL;
    endfunction

    logic [3:0] strap_idx; // Four times strap1 plus strap0
    byte_t wr_addr; // Eight-bit write address
    logic [6:0] dev_addr; // Seven-bit slave address

    // Address table: two slots swap, the rest are linear
    always_comb begin
        strap_idx = {strap_code(seen_low[1], seen_high[1], diff_scl[1]),
                     strap_code(seen_low[0], seen_high[0], diff_scl[0])};
        if (strap_idx == 4'h0) begin
            wr_addr = WR_ADDR_ALT;
        end else if (strap_idx == STRAP_IDX_ALT) begin
            wr_addr = WR_ADDR_BASE;
        end else begin
            wr_addr = WR_ADDR_BASE + {3'h0, strap_idx, 1'b0};
        end
        dev_addr = wr_addr[7:1];
    end

    // ============================================================
    // Interface select and fixed low drive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spi_active <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            spi_active <= mode_s;
            sda_out <= 1'b0; // Open drain only ever pulls low
        end
    end

    // ============================================================
    // Transaction engine
    spi_phase_t spi_phase; // Command or data
    logic spi_read; // Direction of this SPI burst
    logic [2:0] spi_cnt; // Bits of the current SPI byte
    i2c_state_t i2c_state; // I2C byte context
    logic [3:0] i2c_cnt; // Bits of the current I2C byte
    logic in_ack; // Inside the ninth clock
    logic m_ack; // Host acknowledged last byte
    byte_t shift; // Incoming bits
    byte_t tx; // Outgoing byte
    wire byte_t spi_byte = {shift[6:0], mosi_s}; // SPI byte with the bit now sampled

    // One process so both links share the register port without conflict
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_addr <= FIFO_DATA_PORT;
            reg_wdata <= 8'h00;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            spi_phase <= S_CMD;
            spi_read <= 1'b0;
            spi_cnt <= 3'h0;
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
            i2c_state <= I_IDLE;
            i2c_cnt <= 4'h0;
            in_ack <= 1'b0;
            m_ack <= 1'b0;
            sda_oe <= 1'b0;
            shift <= 8'h00;
            tx <= 8'h00;
        end else begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            // Step after each access; data port stays put for streaming
            if ((reg_wr || reg_rd) && reg_addr != FIFO_DATA_PORT) begin
                reg_addr <= reg_addr + ADDR_STEP;
            end
            if (mode_s) begin
                // SPI selected: I2C side held released
                i2c_state <= I_IDLE;
                in_ack <= 1'b0;
                sda_oe <= 1'b0;
                i2c_cnt <= 4'h0;
                if (cs_s) begin
                    // Select high ends any burst
                    spi_phase <= S_CMD;
                    spi_cnt <= 3'h0;
                    serial_out_oe <= 1'b0;
                end else begin
                    // Mode 0: sample on rise
                    if (scl_rise) begin
                        shift <= spi_byte;
                        spi_cnt <= spi_cnt + 3'h1;
                        if (spi_cnt == SPI_LAST_BIT) begin
                            if (spi_phase == S_CMD) begin
                                // Direction then seven-bit address
                                spi_phase <= S_DATA;
                                spi_read <= spi_byte[7];
                                reg_addr <= {1'b0, spi_byte[6:0]};
                            end else if (spi_read) begin
                                reg_rd <= 1'b1;
                            end else begin
                                reg_wdata <= spi_byte;
                                reg_wr <= 1'b1;
                            end
                        end
                    end
                    // Drive on fall so data is stable at the next rise
                    if (scl_fall && spi_phase == S_DATA && spi_read) begin
                        serial_out_oe <= 1'b1;
                        if (spi_cnt == 3'h0) begin
                            // Peek only; the pop comes when the byte is done
                            tx <= reg_rdata;
                            serial_out <= reg_rdata[7];
                        end else begin
                            serial_out <= tx[MSB_IDX - spi_cnt];
                        end
                    end
                end
            end else begin
                // I2C selected: SPI side idle
                spi_phase <= S_CMD;
                spi_cnt <= 3'h0;
                serial_out_oe <= 1'b0;
                if (i2c_start) begin
                    // START or repeated START; address kept for reads
                    i2c_state <= I_DEV;
                    i2c_cnt <= 4'h0;
                    in_ack <= 1'b0;
                    sda_oe <= 1'b0;
                end else if (i2c_stop) begin
                    i2c_state <= I_IDLE;
                    in_ack <= 1'b0;
                    sda_oe <= 1'b0;
                end else if (scl_rise) begin
                    if (in_ack) begin
                        m_ack <= ~sda_s;
                    end else if (i2c_state != I_IDLE && i2c_state != I_IGNORE
                                 && i2c_cnt != I2C_ACK_SLOT) begin
                        shift <= {shift[6:0], sda_s};
                        i2c_cnt <= i2c_cnt + 4'h1;
                    end
                end else if (scl_fall) begin
                    if (in_ack) begin
                        // End of ninth clock: release, maybe start a byte
                        in_ack <= 1'b0;
                        i2c_cnt <= 4'h0;
                        sda_oe <= 1'b0;
                        if (i2c_state == I_RDATA) begin
                            if (m_ack) begin
                                tx <= reg_rdata;
                                sda_oe <= ~reg_rdata[7];
                            end else begin
                                i2c_state <= I_IGNORE;
                            end
                        end
                    end else if (i2c_cnt == I2C_ACK_SLOT) begin
                        in_ack <= 1'b1;
                        unique case (i2c_state)
                            I_DEV: begin
                                if (shift[7:1] == dev_addr) begin
                                    sda_oe <= 1'b1;
                                    m_ack <= 1'b1;
                                    i2c_state <= shift[0] ? I_RDATA : I_REG;
                                end else begin
                                    i2c_state <= I_IGNORE;
                                end
                            end
                            I_REG: begin
                                reg_addr <= shift;
                                if (shift < REG_COUNT) begin
                                    sda_oe <= 1'b1;
                                    i2c_state <= I_WDATA;
                                end else begin
                                    i2c_state <= I_IGNORE;
                                end
                            end
                            I_WDATA: begin
                                sda_oe <= 1'b1;
                                reg_wdata <= shift;
                                reg_wr <= 1'b1;
                            end
                            I_RDATA: begin
                                sda_oe <= 1'b0;
                                reg_rd <= 1'b1;
                            end
                            default: begin
                                i2c_state <= I_IDLE;
                            end
                        endcase
                    end else if (i2c_state == I_RDATA) begin
                        sda_oe <= ~tx[MSB_IDX - i2c_cnt[2:0]];
                    end
                end
            end
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_spi_byte_end;
        mode_s && !cs_s && scl_rise && spi_cnt == SPI_LAST_BIT;
    endsequence

    sequence s_i2c_reg_byte;
        !mode_s && scl_fall && !in_ack && i2c_cnt == I2C_ACK_SLOT
            && i2c_state == I_REG;
    endsequence

    property p_mode_quiet;
        mode_s |=> !sda_oe;
    endproperty
    a_mode_quiet: assert property (p_mode_quiet) else $error("I2C drive in SPI mode");
    property p_cs_end;
        mode_s && cs_s |=> spi_phase == S_CMD && spi_cnt == 3'h0;
    endproperty
    a_cs_end: assert property (p_cs_end) else $error("Burst not ended by select");
    property p_byte_eight;
        s_spi_byte_end ##0 spi_phase == S_DATA && !spi_read |=> reg_wr && spi_cnt == 3'h0;
    endproperty
    a_byte_eight: assert property (p_byte_eight) else $error("SPI write not on bit 8");
    property p_port_stays;
        (reg_wr || reg_rd) && reg_addr == FIFO_DATA_PORT |=> reg_addr == FIFO_DATA_PORT;
    endproperty
    a_port_stays: assert property (p_port_stays) else $error("Data port moved");
    property p_addr_inc;
        (reg_wr || reg_rd) && reg_addr != FIFO_DATA_PORT
            |=> reg_addr == $past(reg_addr) + ADDR_STEP;
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("Address not advanced");
    property p_idle_release;
        i2c_state == I_IDLE || i2c_state == I_IGNORE ##1 !in_ack |-> !sda_oe;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("Idle bus driven");
    property p_start_addr;
        !mode_s && i2c_start |=> i2c_state == I_DEV && !sda_oe;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("START not taken");
    property p_bad_reg_nack;
        s_i2c_reg_byte ##0 shift >= REG_COUNT |=> !sda_oe [*2];
    endproperty
    a_bad_reg_nack: assert property (p_bad_reg_nack) else $error("Bad register acked");
    property p_sda_scl_low;
        !mode_s && $changed(sda_oe) |-> !scl_s || !sda_oe;
    endproperty
    a_sda_scl_low: assert property (p_sda_scl_low) else $error("SDA pulled with SCL high");
    property p_host_nack;
        !mode_s && i2c_state == I_RDATA && in_ack && scl_fall && !m_ack
            |=> i2c_state == I_IGNORE && !sda_oe;
    endproperty
    a_host_nack: assert property (p_host_nack) else $error("Sent after host nack");

endmodule // host_serial_port

`default_nettype wire

// ### testbench/host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Host master: SPI mode 0 or I2C master with strapped pins
module host_model (
    // Clock and strap settings
    input wire logic clk,
    input wire logic spi_mode,
    input wire logic [1:0] strap0,
    input wire logic [1:0] strap1,
    // Pins towards the device
    output var logic sclk_scl,
    output var logic select_or_strap0,
    output var logic serial_in_or_strap1,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic sda_oe,
    output var logic sda_wire
);
    import host_port_pkg::*;
    logic cs_n = 1'b1; // Chip select, idles high
    logic mosi = 1'b0; // Serial data from the host
    logic sda_low = 1'b0; // Host pulls data low
    byte_t rxb [8]; // Bytes taken in the last transfer
    // Open-drain data line with pull-up
    assign sda_wire = !(sda_low || sda_oe);
    // Level on a strap pin; args keep the assign sensitive to both lines
    function automatic logic lvl(input logic [1:0] s, input logic c, input logic d);
        return (s == STRAP_GND) ? 1'b0 : (s == STRAP_VL) ? 1'b1 : (s == STRAP_SCL) ? c : d;
    endfunction
    // Shared pins: SPI controls or I2C straps
    assign select_or_strap0 = spi_mode ? cs_n : lvl(strap0, sclk_scl, sda_wire);
    assign serial_in_or_strap1 = spi_mode ? mosi : lvl(strap1, sclk_scl, sda_wire);
    // Wait on falling clock edges so pins change off the sampling edge
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Idle bus: SPI clock low, I2C lines released
    task automatic set_idle(input logic spi);
        sclk_scl = !spi;
        cs_n = 1'b1;
        sda_low = 1'b0;
    endtask
    // One SPI byte, MSB first, set while clock low, sampled on rise
    task automatic spi_byte(input byte_t tx, output byte_t rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            w(16);
            sclk_scl = 1'b1;
            rx[i] = serial_out_oe ? serial_out : !serial_out; // Undriven line reads wrong
            w(16);
            sclk_scl = 1'b0;
        end
    endtask
    // Whole SPI transaction with n data bytes d0, d0+1, ...
    task automatic spi_xfer(input logic rd, input byte_t a, input int n, input byte_t d0);
        byte_t junk;
        cs_n = 1'b0;
        w(16);
        spi_byte({rd, a[6:0]}, junk);
        for (int i = 0; i < n; i++) begin
            spi_byte(d0 + byte_t'(i), rxb[i]);
        end
        w(16);
        cs_n = 1'b1;
        mosi = !mosi; // Released line must not hold a stale bit
        w(32);
    endtask
    // One I2C bit; data moves only while clock is low
    task automatic i2c_bit(input logic b, output logic r);
        w(8);
        sda_low = !b;
        w(8);
        sclk_scl = 1'b1;
        w(8);
        r = sda_wire;
        w(8);
        sclk_scl = 0;
    endtask
    // START or repeated START
    task automatic i2c_start();
        w(8);
        sda_low = 1'b0;
        w(8);
        sclk_scl = 1'b1;
        w(16);
        sda_low = 1'b1;
        w(16);
        sclk_scl = 1'b0;
    endtask
    // STOP leaves both lines released
    task automatic i2c_stop();
        w(8);
        sda_low = 1'b1;
        w(8);
        sclk_scl = 1'b1;
        w(16);
        sda_low = 1'b0;
        w(16);
    endtask
    // Eight bits then the ninth slot; nine is what the host puts there
    task automatic i2c_byte(input byte_t tx, input logic nine, output byte_t rx, output logic s);
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(tx[i], rx[i]);
        end
        i2c_bit(nine, s);
    endtask
endmodule // host_model
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define H host_model_inst
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    $display("Error %s expected %h seen %h", nm, exp, got); fail_count++; end end
// ============================================================
// Bench: SPI accesses, then I2C straps and accesses
module tb;
    import host_port_pkg::*;
    logic clk = 1'b0; // System clock
    logic rst_n = 1'b0; // Reset, active low
    logic spi_select = 1'b1; // Mode strap, SPI first
    logic [1:0] strap0 = STRAP_VL; // I2C address straps
    logic [1:0] strap1 = STRAP_VL;
    wire logic sclk_scl, cs_pin, mosi_pin, sda_w;
    logic serial_out, serial_out_oe, sda_out, sda_oe, reg_wr, reg_rd, spi_active;
    byte_t reg_addr, reg_wdata, reg_rdata, dev, q0;
    byte_t rx_head = 8'h30; // Head of the modelled receive queue
    logic [15:0] wlog [$]; // Writes seen, address and data
    logic stray_oe = 1'b0; // Unused interface drove its pin
    int fail_count = 0;
    int samples_checked = 0;
    always #2.5 clk = !clk;
    host_serial_port host_serial_port_inst (.clk(clk), .rst_n(rst_n), .spi_select(spi_select),
        .sclk_scl(sclk_scl), .select_or_strap0(cs_pin), .serial_in_or_strap1(mosi_pin),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spi_active(spi_active));
    host_model host_model_inst (.clk(clk), .spi_mode(spi_select), .strap0(strap0),
        .strap1(strap1), .sclk_scl(sclk_scl), .select_or_strap0(cs_pin),
        .serial_in_or_strap1(mosi_pin), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .sda_oe(sda_oe), .sda_wire(sda_w));
    // ============================================================
    // Register side: queue head at port zero, a fixed pattern elsewhere
    assign reg_rdata = (reg_addr == FIFO_DATA_PORT) ? rx_head : (reg_addr ^ 8'h5a);
    always @(posedge clk) begin
        if (reg_wr === 1'b1) begin
            wlog.push_back({reg_addr, reg_wdata});
        end
        // Pop only on a consumed read of the queue port
        if (reg_rd === 1'b1 && reg_addr == FIFO_DATA_PORT) begin
            rx_head <= rx_head + 8'h01;
        end
        if ((spi_select ? sda_oe : serial_out_oe) === 1'b1) begin
            stray_oe <= 1'b1;
        end
    end
    // ============================================================
    // Tasks
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Called after straps and mode change, so learned straps restart from reset
    task automatic reset_dut();
        rst_n = 1'b0;
        `H.set_idle(spi_select);
        stray_oe = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("mode", spi_select, spi_active)
        `CHK("sda level", 1'b0, sda_out)
    endtask
    // Logged writes must be n bytes d0.. at a0 stepping by step
    task automatic chk_log(input byte_t a0, input byte_t step, input int n, input byte_t d0);
        `CHK("write count", n, wlog.size())
        foreach (wlog[i]) begin
            `CHK("write", {a0 + step * byte_t'(i), d0 + byte_t'(i)}, wlog[i])
        end
        wlog.delete();
    endtask
    // Read bytes: queue entries at port zero, pattern elsewhere
    task automatic chk_rd(input byte_t a, input int n, input byte_t h);
        for (int i = 0; i < n; i++) begin
            `CHK("read", (a == 8'h00) ? h + byte_t'(i) : (a + byte_t'(i)) ^ 8'h5a, `H.rxb[i])
        end
        if (a == 8'h00) `CHK("pops", h + byte_t'(n), rx_head)
    endtask
    // Address byte alone, then STOP
    task automatic i2c_probe(input byte_t a, input logic nack);
        byte_t rx;
        logic s;
        `H.i2c_start();
        `H.i2c_byte(a, 1'b1, rx, s);
        `H.i2c_stop();
        `CHK("slave address ack", nack, s)
    endtask
    // START, slave address with write bit, register address
    task automatic i2c_head(input byte_t ra, input logic ok);
        byte_t rx;
        logic s;
        `H.i2c_start();
        `H.i2c_byte(dev, 1'b1, rx, s);
        `CHK("address ack", 1'b0, s)
        `H.i2c_byte(ra, 1'b1, rx, s);
        `CHK("register ack", !ok, s)
    endtask
    task automatic i2c_wr(input byte_t ra, input int n, input byte_t d0, input logic ok);
        byte_t rx;
        logic s;
        i2c_head(ra, ok);
        for (int i = 0; i < n; i++) begin
            `H.i2c_byte(d0 + byte_t'(i), 1'b1, rx, s);
            `CHK("data ack", 1'b0, s)
        end
        `H.i2c_stop();
        `CHK("idle release", 1'b0, sda_oe)
    endtask
    // Host acks all but the last byte, which it refuses
    task automatic i2c_rd(input byte_t ra, input int n);
        logic s;
        i2c_head(ra, 1'b1);
        `H.i2c_start();
        `H.i2c_byte(dev | 8'h01, 1'b1, `H.rxb[0], s);
        `CHK("read address ack", 1'b0, s)
        for (int i = 0; i < n; i++) begin
            `H.i2c_byte(8'hff, i == n - 1, `H.rxb[i], s);
        end
        `H.i2c_stop();
    endtask
    // ============================================================
    // Watchdog, well beyond the expected run of about 125 us
    initial begin
        #400000;
        fail_count++;
        $display("Error watchdog expected done seen timeout");
        finish_test();
    end
    initial begin
        reset_dut();
        `H.spi_xfer(1'b0, 8'h05, 3, 8'ha0);
        chk_log(8'h05, 8'h01, 3, 8'ha0);
        `H.spi_xfer(1'b0, 8'h00, 3, 8'h11);
        chk_log(8'h00, 8'h00, 3, 8'h11);
        `H.spi_xfer(1'b0, 8'h09, 0, 8'h00);
        `H.spi_xfer(1'b0, 8'h02, 1, 8'h77);
        chk_log(8'h02, 8'h01, 1, 8'h77);
        q0 = rx_head;
        `H.spi_xfer(1'b1, 8'h00, 3, 8'h00);
        chk_rd(8'h00, 3, q0);
        `H.spi_xfer(1'b1, 8'h1d, 3, 8'h00);
        chk_rd(8'h1d, 3, 8'h00);
        `CHK("idle pin", 1'b0, stray_oe)
        $display("Test spi done");
        spi_select = 1'b0;
        for (int k = 0; k < 16; k++) begin
            strap1 = 2'(k / 4);
            strap0 = 2'(k % 4);
            dev = (k == 0) ? WR_ADDR_ALT : (4'(k) == STRAP_IDX_ALT) ? WR_ADDR_BASE
                : WR_ADDR_BASE + byte_t'(2 * k);
            reset_dut();
            i2c_probe(dev ^ 8'h02, 1'b1);
            i2c_probe(dev, 1'b0);
        end
        $display("Test straps done");
        i2c_wr(8'h05, 3, 8'hb0, 1'b1);
        chk_log(8'h05, 8'h01, 3, 8'hb0);
        i2c_wr(8'h00, 2, 8'hc0, 1'b1);
        chk_log(8'h00, 8'h00, 2, 8'hc0);
        i2c_wr(8'h25, 0, 8'h00, 1'b0);
        chk_log(8'h00, 8'h00, 0, 8'h00);
        i2c_rd(8'h1d, 3);
        chk_rd(8'h1d, 3, 8'h00);
        q0 = rx_head;
        i2c_rd(8'h00, 3);
        chk_rd(8'h00, 3, q0);
        `CHK("idle pin", 1'b0, stray_oe)
        $display("Test i2c done");
        finish_test();
    end
endmodule // tb
`default_nettype wire
